/* hw/ssp_core.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ssp_map.svh"
module ssp_core
    import ssp_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    // Software access
    input wire logic i_con_wr,
    input wire logic i_stat_wr,
    input wire logic i_buf_wr,
    input wire logic i_buf_rd,
    input wire logic i_addr_wr,
    input wire logic i_flag_clr,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_serial_control_reg1,
    output logic [7:0] o_serial_status_reg,
    output logic [7:0] o_serial_data_buffer,
    output logic [7:0] o_serial_addr_baud_reg,
    output logic o_serial_irq_flag,
    // Pin directions, 1 = input
    input wire logic i_dir_sdi,
    input wire logic i_dir_sdo,
    input wire logic i_dir_sck,
    input wire logic i_dir_ss,
    // Serial pins
    input wire logic i_sck,
    output logic o_sck,
    output logic o_sck_oe,
    input wire logic i_sdi,
    output logic o_sdo,
    output logic o_sdo_oe,
    input wire logic i_ss_n
);
    logic [7:0] con_reg;
    logic [1:0] stat_hi_reg;
    logic bf_reg;
    ssp_byte_t buf_reg;
    ssp_byte_t sr_reg;
    logic [7:0] addr_reg;
    logic flag_reg;
    ssp_state_e state_reg;
    logic [3:0] bits_reg;
    logic phase_reg;
    logic sck_reg;
    logic sdo_reg;
    logic sdi_bit_reg;
    logic sck_s;
    logic sdi_s;
    logic ss_s;
    logic sck_d_reg;
    logic tick;
    logic en;
    logic master;
    logic ckp;
    logic cke;
    logic smp;
    logic [3:0] mode;
    logic done;
    logic sdi_in;

    assign en = con_reg[`SSP_CON_EN_BIT];
    assign ckp = con_reg[`SSP_CON_CKP_BIT];
    assign mode = con_reg[3:0];
    assign smp = stat_hi_reg[1];
    assign cke = stat_hi_reg[0];
    assign master = (mode == `SSP_MODE_M4) || (mode == `SSP_MODE_M16) ||
                    (mode == `SSP_MODE_M64) || (mode == `SSP_MODE_BAUD);

    ssp_sync u_sync_sck (.i_clk(i_clk), .i_resetn(i_resetn), .i_d(i_sck), .o_q(sck_s));
    ssp_sync u_sync_sdi (.i_clk(i_clk), .i_resetn(i_resetn), .i_d(i_sdi), .o_q(sdi_s));
    ssp_sync u_sync_ss (.i_clk(i_clk), .i_resetn(i_resetn), .i_d(i_ss_n), .o_q(ss_s));
    // Data-in pin given to another function reads as zero
    assign sdi_in = sdi_s && i_dir_sdi;

    ssp_baud u_baud (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_run(en && master && (state_reg == SSP_RUN)),
        .i_mode(mode),
        .i_reload(addr_reg),
        .o_tick(tick)
    );

    // Slave clock edges; leading edge leaves idle level
    logic s_lead;
    logic s_trail;
    logic s_sel;
    assign s_sel = (mode != `SSP_MODE_SL_SS) || !i_dir_ss || !ss_s;
    assign s_lead = (sck_s != sck_d_reg) && (sck_s != ckp);
    assign s_trail = (sck_s != sck_d_reg) && (sck_s == ckp);

    // Output-change and sample events, per CKE and SMP
    logic ev_lead;
    logic ev_trail;
    logic ev_shift;
    logic ev_samp;
    assign ev_lead = master ? (tick && !phase_reg) : (s_lead && s_sel);
    assign ev_trail = master ? (tick && phase_reg) : (s_trail && s_sel);
    assign ev_shift = cke ? ev_trail : ev_lead;
    assign ev_samp = (master && smp) ? ev_shift : (cke ? ev_lead : ev_trail);
    assign done = (state_reg == SSP_RUN) && ev_trail && (bits_reg == `SSP_BIT_COUNT - 4'h1);

    // Control registers
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            con_reg <= `SSP_CON_RESET;
            stat_hi_reg <= 2'b00;
            addr_reg <= 8'h00;
        end else begin
            if (i_con_wr) begin
                con_reg <= i_wdata;
            end
            if (i_stat_wr) begin
                stat_hi_reg <= i_wdata[7:6];
            end
            if (i_addr_wr) begin
                addr_reg <= i_wdata;
            end
        end
    end

    // Transfer sequencer
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_reg <= SSP_IDLE;
            bits_reg <= 4'h0;
            phase_reg <= 1'b0;
        end else if (!en) begin
            state_reg <= SSP_IDLE;
            bits_reg <= 4'h0;
            phase_reg <= 1'b0;
        end else begin
            case (state_reg)
                SSP_IDLE: begin
                    bits_reg <= 4'h0;
                    phase_reg <= 1'b0;
                    if (i_buf_wr || (!master && s_lead && s_sel)) begin
                        state_reg <= SSP_RUN;
                    end
                end
                SSP_RUN: begin
                    if (master && tick) begin
                        phase_reg <= !phase_reg;
                    end
                    if (ev_trail) begin
                        bits_reg <= bits_reg + 4'h1;
                    end
                    if (done) begin
                        state_reg <= SSP_DONE;
                    end
                end
                SSP_DONE: state_reg <= SSP_IDLE;
                default: state_reg <= SSP_IDLE;
            endcase
        end
    end

    // Shift register, buffer and flags
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            sr_reg <= 8'h00;
            buf_reg <= 8'h00;
            bf_reg <= 1'b0;
            flag_reg <= 1'b0;
            sdo_reg <= 1'b0;
            sdi_bit_reg <= 1'b0;
            sck_d_reg <= 1'b0;
        end else begin
            sck_d_reg <= sck_s;
            if (ev_samp && state_reg != SSP_DONE) begin
                sdi_bit_reg <= sdi_in;
            end
            if (i_buf_wr) begin
                buf_reg <= i_wdata;
                sr_reg <= i_wdata;
                sdo_reg <= i_wdata[7];
            end else if (state_reg == SSP_RUN && ev_shift && !(cke == 1'b0 && bits_reg == 4'h0 && !phase_reg)) begin
                sr_reg <= {sr_reg[6:0], sdi_bit_reg};
                sdo_reg <= sr_reg[6];
            end
            if (done) begin
                buf_reg <= cke ? {sr_reg[6:0], sdi_bit_reg} : {sr_reg[6:0], (ev_samp ? sdi_in : sdi_bit_reg)};
                bf_reg <= 1'b1;
            end else if (i_buf_rd) begin
                bf_reg <= 1'b0;
            end
            if (done) begin
                flag_reg <= 1'b1;
            end else if (i_flag_clr) begin
                flag_reg <= 1'b0;
            end
        end
    end

    // Pin drive
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            sck_reg <= 1'b0;
            o_sck <= 1'b0;
            o_sck_oe <= 1'b0;
            o_sdo <= 1'b0;
            o_sdo_oe <= 1'b0;
        end else begin
            if (state_reg != SSP_RUN) begin
                sck_reg <= ckp;
            end else if (master && tick) begin
                sck_reg <= !sck_reg;
            end
            o_sck <= sck_reg;
            o_sck_oe <= en && master && !i_dir_sck;
            o_sdo <= sdo_reg;
            o_sdo_oe <= en && !i_dir_sdo && (master || s_sel);
        end
    end

    // Register views
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_serial_control_reg1 <= `SSP_CON_RESET;
            o_serial_status_reg <= `SSP_STAT_RESET;
            o_serial_data_buffer <= 8'h00;
            o_serial_addr_baud_reg <= 8'h00;
            o_serial_irq_flag <= 1'b0;
        end else begin
            o_serial_control_reg1 <= con_reg;
            o_serial_status_reg <= {stat_hi_reg, 5'h00, bf_reg};
            o_serial_data_buffer <= buf_reg;
            o_serial_addr_baud_reg <= addr_reg;
            o_serial_irq_flag <= flag_reg;
        end
    end
endmodule // ssp_core
`default_nettype wire

/* hw/ssp_map.svh */
// Functional notes
// - A complete received byte is copied to the data buffer and sets the flag.
// - A data buffer write loads buffer and shift register together; a byte completed in the same cycle takes the buffer instead.
// - The shift register is reached by software only through the data buffer.
// - Control register fully read/write; status low six read-only, top two read/write.
// - Master drives the serial clock; slave takes it from the master.
// - Polarity sets clock idle level; edge bit picks the output-change edge.
// - Sample bit picks input sampling at middle or end of output time, as master only; slave samples at the middle.
// - Clock rate used only as master; slave-select mode only as slave.
// - Enable hands data-in, data-out, clock and select pins to the port.
// - A pin direction opposite to the needed one disables that function, except the slave clock input, which is taken whatever its direction.
// - In one master mode the address register sets the clock rate.
`ifndef SSP_MAP_SVH
`define SSP_MAP_SVH
`define SSP_CON_EN_BIT 5
`define SSP_CON_CKP_BIT 4
`define SSP_STAT_SMP_BIT 7
`define SSP_STAT_CKE_BIT 6
`define SSP_STAT_BF_BIT 0
`define SSP_MODE_M4 4'h0
`define SSP_MODE_M16 4'h1
`define SSP_MODE_M64 4'h2
`define SSP_MODE_BAUD 4'hA
`define SSP_MODE_SL_SS 4'h4
`define SSP_MODE_SL 4'h5
`define SSP_CON_RESET 8'h00
`define SSP_STAT_RESET 8'h00
`define SSP_BIT_COUNT 4'h8
`endif

/* hw/ssp_pkg.sv */
`default_nettype none
package ssp_pkg;
    typedef enum logic [2:0] {
        SSP_IDLE = 3'b001,
        SSP_RUN = 3'b010,
        SSP_DONE = 3'b100
    } ssp_state_e;
    typedef logic [7:0] ssp_byte_t;
endpackage
`default_nettype wire

/* hw/ssp_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module ssp_sync (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    // Async level
    input wire logic i_d,
    output logic o_q
);
    logic meta_reg;
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            meta_reg <= 1'b0;
            o_q <= 1'b0;
        end else begin
            meta_reg <= i_d;
            o_q <= meta_reg;
        end
    end
endmodule // ssp_sync
`default_nettype wire

/* hw/ssp_baud.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ssp_map.svh"
module ssp_baud
    import ssp_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    // Control
    input wire logic i_run,
    input wire logic [3:0] i_mode,
    input wire logic [7:0] i_reload,
    // Half-period tick
    output logic o_tick
);
    logic [7:0] cnt_reg;
    logic [7:0] limit;
    always_comb begin
        case (i_mode)
            `SSP_MODE_M4: limit = 8'h00;
            `SSP_MODE_M16: limit = 8'h03;
            `SSP_MODE_M64: limit = 8'h0F;
            `SSP_MODE_BAUD: limit = i_reload;
            default: limit = 8'h00;
        endcase
    end
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cnt_reg <= 8'h00;
            o_tick <= 1'b0;
        end else if (!i_run) begin
            cnt_reg <= 8'h00;
            o_tick <= 1'b0;
        end else if (cnt_reg >= limit) begin
            cnt_reg <= 8'h00;
            o_tick <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + 8'h01;
            o_tick <= 1'b0;
        end
    end
endmodule // ssp_baud
`default_nettype wire

/* testbench/ssp_core_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module ssp_core_chk (
    // Watched ports
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_con_wr,
    input wire logic i_stat_wr,
    input wire logic i_buf_wr,
    input wire logic [7:0] i_wdata,
    input wire logic i_dir_sdo,
    input wire logic i_dir_sck,
    input wire logic [7:0] o_serial_control_reg1,
    input wire logic [7:0] o_serial_status_reg,
    input wire logic [7:0] o_serial_data_buffer,
    input wire logic o_serial_irq_flag,
    input wire logic o_sck,
    input wire logic o_sck_oe,
    input wire logic o_sdo_oe
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    ctl_write_a: assert property (i_con_wr |-> ##2 o_serial_control_reg1 == $past(i_wdata, 2))
        else $error("control readback");
    stat_write_a: assert property (i_stat_wr |-> ##2 o_serial_status_reg[7:6] == $past(i_wdata[7:6], 2))
        else $error("status mode bits");
    stat_ro_a: assert property (o_serial_status_reg[5:1] == 5'h00)
        else $error("status low bits");
    buf_load_a: assert property (i_buf_wr |-> ##2 o_serial_data_buffer == $past(i_wdata, 2))
        else $error("buffer load");
    sck_idle_a: assert property ($rose(o_serial_irq_flag) && !o_serial_control_reg1[2] |-> o_sck == o_serial_control_reg1[4])
        else $error("clock not idle");
    full_flag_a: assert property ($rose(o_serial_irq_flag) |-> ##[0:2] o_serial_status_reg[0])
        else $error("buffer full");
    dir_sck_a: assert property (i_dir_sck [*2] |-> !o_sck_oe)
        else $error("clock driven");
    dir_sdo_a: assert property (i_dir_sdo [*2] |-> !o_sdo_oe)
        else $error("data driven");
endmodule // ssp_core_chk
bind ssp_core ssp_core_chk u_chk (.i_clk, .i_resetn, .i_con_wr, .i_stat_wr, .i_buf_wr, .i_wdata, .i_dir_sdo,
    .i_dir_sck, .o_serial_control_reg1, .o_serial_status_reg, .o_serial_data_buffer, .o_serial_irq_flag,
    .o_sck, .o_sck_oe, .o_sdo_oe);
`default_nettype wire

/* testbench/ssp_spi_slave.sv */
`timescale 1ns/1ps
`default_nettype none
module ssp_spi_slave (
    // Master side
    input wire logic i_sck,
    input wire logic i_sel_n,
    input wire logic i_cke,
    input wire logic [7:0] i_byte,
    output logic o_miso
);
    logic [7:0] sh;
    logic idle;
    logic first;
    initial o_miso = 1'b0;
    always @(negedge i_sel_n) begin
        idle = i_sck;
        first = 1'b1;
        sh = i_byte;
        o_miso = sh[7];
    end
    // Line toggles on release
    always @(posedge i_sel_n) o_miso = ~o_miso;
    // Data changes on trailing edges, or on leading edges after the first
    always @(i_sck) begin
        if (!i_sel_n && ((i_sck == idle) == i_cke)) begin
            if (first && !i_cke) begin
                first = 1'b0;
            end else begin
                sh = {sh[6:0], 1'b0};
                o_miso = sh[7];
            end
        end
    end
endmodule // ssp_spi_slave
`default_nettype wire

/* testbench/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic i_clk, i_resetn, i_con_wr, i_stat_wr, i_buf_wr, i_buf_rd, i_addr_wr, i_flag_clr, flag;
    logic i_dir_sdi, i_dir_sdo, i_dir_sck, i_dir_ss, i_sck, o_sck, o_sck_oe, i_sdi, o_sdo, o_sdo_oe, i_ss_n;
    logic [7:0] i_wdata, ctl, sta, dbf, adr, s_byte;
    int miscompares, checks;
    ssp_core dut (.i_clk, .i_resetn, .i_con_wr, .i_stat_wr, .i_buf_wr, .i_buf_rd, .i_addr_wr, .i_flag_clr,
        .i_wdata, .o_serial_control_reg1(ctl), .o_serial_status_reg(sta), .o_serial_data_buffer(dbf),
        .o_serial_addr_baud_reg(adr), .o_serial_irq_flag(flag), .i_dir_sdi, .i_dir_sdo, .i_dir_sck,
        .i_dir_ss, .i_sck, .o_sck, .o_sck_oe, .i_sdi, .o_sdo, .o_sdo_oe, .i_ss_n);
    ssp_spi_slave u_slave (.i_sck(o_sck_oe ? o_sck : i_sck), .i_sel_n(i_ss_n), .i_cke(sta[6]), .i_byte(s_byte),
        .o_miso(i_sdi));
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(ref logic s, input logic [7:0] d);
        @(negedge i_clk);
        s = 1'b1;
        i_wdata = d;
        @(negedge i_clk);
        s = 1'b0;
    endtask
    task automatic conclude();
        if (miscompares == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic xfer(input logic [7:0] tx, input logic [7:0] rx, input int half);
        int tg = 0, gap = 0, bad = 0;
        logic [7:0] got = 8'h00;
        logic last;
        last = ctl[4];
        s_byte = rx;
        i_ss_n = 1'b0;
        wr(i_buf_wr, tx);
        for (int n = 0; n < 3000 && flag !== 1'b1; n++) begin
            @(negedge i_clk);
            gap++;
            if (o_sck !== last) begin
                if (tg > 0 && gap != half) bad++;
                if (last === ctl[4]) got = {got[6:0], o_sdo};
                tg++;
                gap = 0;
                last = o_sck;
            end
        end
        chk("flag", 8'h01, {7'h00, flag});
        repeat (2) @(negedge i_clk);
        chk("edges", 8'h10, 8'(tg));
        chk("half period", 8'h00, 8'(bad));
        chk("idle clock", {7'h00, ctl[4]}, {7'h00, o_sck});
        chk("sent", tx, got);
        if (half > 1) chk("received", rx, dbf);
        chk("full", 8'h01, {7'h00, sta[0]});
        i_ss_n = 1'b1;
        wr(i_flag_clr, 8'h00);
        wr(i_buf_rd, 8'h00);
        repeat (2) @(negedge i_clk);
        chk("cleared", 8'h00, {6'h00, flag, sta[0]});
    endtask
    task automatic t_regs();
        @(negedge i_clk);
        chk("reset", 8'h00, ctl | sta | {5'h00, o_sck_oe, o_sdo_oe, flag});
        wr(i_con_wr, 8'h1A);
        wr(i_stat_wr, 8'hFF);
        wr(i_addr_wr, 8'h03);
        @(negedge i_clk);
        chk("control", 8'h1A, ctl);
        chk("status", 8'hC0, sta);
        chk("address", 8'h03, adr);
        wr(i_stat_wr, 8'h00);
        wr(i_buf_wr, 8'h5A);
        repeat (40) @(negedge i_clk);
        chk("disabled", 8'h00, {5'h00, o_sck_oe, o_sdo_oe, flag});
        chk("buffer", 8'h5A, dbf);
    endtask
    task automatic t_dir();
        i_dir_sck = 1'b1;
        i_dir_sdo = 1'b1;
        wr(i_con_wr, 8'h21);
        repeat (3) @(negedge i_clk);
        chk("override oe", 8'h00, {6'h00, o_sck_oe, o_sdo_oe});
        i_dir_sck = 1'b0;
        i_dir_sdo = 1'b0;
        repeat (3) @(negedge i_clk);
        chk("master oe", 8'h03, {6'h00, o_sck_oe, o_sdo_oe});
    endtask
    task automatic t_master();
        logic [7:0] cfg [6] = '{8'h20, 8'h21, 8'h22, 8'h2A, 8'h31, 8'h21};
        int half [6] = '{1, 4, 16, 4, 4, 4};
        for (int k = 0; k < 6; k++) begin
            wr(i_con_wr, cfg[k] & 8'hDF);
            wr(i_stat_wr, (k == 5) ? 8'h40 : 8'h00);
            wr(i_con_wr, cfg[k]);
            repeat (3) @(negedge i_clk);
            xfer(8'hA5 ^ 8'(k), 8'h3C ^ 8'(k * 3), half[k]);
        end
    endtask
    task automatic t_slave();
        logic [7:0] got = 8'h00;
        i_dir_sck = 1'b1;
        wr(i_stat_wr, 8'h00);
        wr(i_con_wr, 8'h04);
        wr(i_con_wr, 8'h24);
        s_byte = 8'h96;
        i_ss_n = 1'b0;
        wr(i_buf_wr, 8'h69);
        repeat (4) @(negedge i_clk);
        chk("slave oe", 8'h01, {6'h00, o_sck_oe, o_sdo_oe});
        for (int b = 0; b < 8; b++) begin
            i_sck = 1'b1;
            repeat (8) @(negedge i_clk);
            got = {got[6:0], o_sdo};
            i_sck = 1'b0;
            repeat (8) @(negedge i_clk);
        end
        chk("slave sent", 8'h69, got);
        chk("slave received", 8'h96, dbf);
        chk("slave flag", 8'h03, {6'h00, flag, sta[0]});
        i_ss_n = 1'b1;
        repeat (4) @(negedge i_clk);
        chk("deselect", 8'h00, {7'h00, o_sdo_oe});
    endtask
    initial begin
        {i_con_wr, i_stat_wr, i_buf_wr, i_buf_rd, i_addr_wr, i_flag_clr} = 6'h00;
        {i_dir_sdo, i_dir_sck, i_sck, i_resetn} = 4'h0;
        {i_dir_sdi, i_dir_ss, i_ss_n} = 3'h7;
        i_wdata = 8'h00;
        s_byte = 8'h00;
        miscompares = 0;
        checks = 0;
        repeat (10) @(negedge i_clk);
        i_resetn = 1'b1;
        t_regs();
        t_dir();
        t_master();
        t_slave();
        conclude();
    end
    initial begin
        repeat (20000) @(posedge i_clk);
        miscompares++;
        conclude();
    end
endmodule // tb
`default_nettype wire
